/* npo_consts.vh */
// npo_consts.vh: constants for the offload-header driver-side controller
// assumes: included by every design file of the controller, definitions only
`ifndef NPO_CONSTS_VH
`define NPO_CONSTS_VH

// header geometry (12 bytes, little-endian fields)
`define NPO_HDR_BYTES       4'd12
`define NPO_HDR_LAST        4'd11
// header byte positions
`define NPO_B_FLAGS         4'd0
`define NPO_B_KIND          4'd1
`define NPO_B_HLEN          4'd2
`define NPO_B_SEGSZ         4'd4
`define NPO_B_CSTART        4'd6
`define NPO_B_CPOS          4'd8
`define NPO_B_NBUF          4'd10
// flag bits
`define NPO_FLAG_NEEDS_CSUM 8'h01
`define NPO_FLAG_DATA_VALID 8'h02
`define NPO_FLAG_COAL_INFO  8'h04
// segmentation kinds
`define NPO_KIND_NONE       8'h00
`define NPO_KIND_TCP4       8'h01
`define NPO_KIND_UDP        8'h03
`define NPO_KIND_TCP6       8'h04
`define NPO_KIND_CONG_BIT   8'h80
`define NPO_KIND_MASK       8'h7f
// receive buffer minimum sizes
`define NPO_RXBUF_MIN_LARGE 17'd65562
`define NPO_RXBUF_MIN_SMALL 17'd1526
`define NPO_RXBUF_MIN_MERGE 17'd12
// apb register byte offsets
`define NPO_REG_CTRL        8'h00
`define NPO_REG_FEAT        8'h04
`define NPO_REG_TXA         8'h08
`define NPO_REG_TXB         8'h0c
`define NPO_REG_STAT        8'h10
`define NPO_REG_RXA         8'h14
`define NPO_REG_RXB         8'h18
`define NPO_REG_RXC         8'h1c
`define NPO_REG_BUFSZ       8'h20
// feature register bits
`define NPO_F_CSUM          0
`define NPO_F_TX_TCP4       1
`define NPO_F_TX_TCP6       2
`define NPO_F_TX_UDP        3
`define NPO_F_TX_CONG       4
`define NPO_F_RX_TCP4       5
`define NPO_F_RX_TCP6       6
`define NPO_F_RX_UDP        7
`define NPO_F_RX_COAL       8
`define NPO_F_MERGE         9
`define NPO_F_MQ            10
`define NPO_F_GUEST_CSUM    11
`define NPO_FEAT_W          12
// ctrl bits
`define NPO_C_GO            0
`define NPO_C_ECN           1
`define NPO_C_CSUM          2

`endif

/* npo_tx_hdr_build.v */
// npo_tx_hdr_build.v: forms a legal transmit offload header from a software request
// assumes: request fields and features are stable while used; pure logic
`timescale 1ns/1ps
`default_nettype none
`include "npo_consts.vh"

module npo_tx_hdr_build (
  // request
  input  wire [`NPO_FEAT_W-1:0] feat,
  input  wire [7:0]             req_kind,
  input  wire                   req_ecn,
  input  wire                   req_csum,
  input  wire [15:0]            req_hlen,
  input  wire [15:0]            req_segsz,
  input  wire [15:0]            req_cstart,
  input  wire [15:0]            req_cpos,
  // formed header
  output reg  [95:0]            hdr,
  output reg                    bad
);

  reg        seg_any;
  reg        kind_ok;
  reg [7:0]  kind;
  reg [7:0]  flags;

  always @*
  begin
    seg_any = feat[`NPO_F_TX_TCP4] | feat[`NPO_F_TX_TCP6] | feat[`NPO_F_TX_UDP];
    // kinds only when their feature exists
    case (req_kind)
      `NPO_KIND_NONE: kind_ok = 1'b1;
      `NPO_KIND_TCP4: kind_ok = feat[`NPO_F_TX_TCP4];
      `NPO_KIND_TCP6: kind_ok = feat[`NPO_F_TX_TCP6];
      `NPO_KIND_UDP:  kind_ok = feat[`NPO_F_TX_UDP];
      default:        kind_ok = 1'b0;
    endcase
    kind = (kind_ok && seg_any) ? req_kind : `NPO_KIND_NONE;
    // ecn-marked segmented tcp only with the feature, then bit set
    bad = !kind_ok || (req_ecn && kind != `NPO_KIND_NONE && kind != `NPO_KIND_UDP
          && !feat[`NPO_F_TX_CONG]);
    if (req_ecn && feat[`NPO_F_TX_CONG] && kind != `NPO_KIND_NONE)
      kind = kind | `NPO_KIND_CONG_BIT;
    // flags zero without checksum offload; data-valid/coalesce never set
    flags = 8'h00;
    if (feat[`NPO_F_CSUM] && (req_csum || kind != `NPO_KIND_NONE))
      flags = `NPO_FLAG_NEEDS_CSUM; // segmentation forces needs-checksum
    // segmenting needs the checksum flag, which is illegal without offload
    if (!feat[`NPO_F_CSUM] && (req_csum || kind != `NPO_KIND_NONE))
      bad = 1'b1;
    // little-endian layout, buffer count zero on transmit
    hdr = {16'h0000,
           (flags != 8'h00) ? req_cpos   : 16'h0000,
           (flags != 8'h00) ? req_cstart : 16'h0000,
           (kind != `NPO_KIND_NONE) ? req_segsz : 16'h0000,
           seg_any ? req_hlen : 16'h0000,
           kind, flags};
  end

endmodule // npo_tx_hdr_build
`default_nettype wire

/* npo_rx_hdr_check.v */
// npo_rx_hdr_check.v: interprets a received offload header as the driver must
// assumes: header captured whole; pure logic
`timescale 1ns/1ps
`default_nettype none
`include "npo_consts.vh"

module npo_rx_hdr_check (
  // input
  input  wire [`NPO_FEAT_W-1:0] feat,
  input  wire [95:0]            hdr,
  // interpretation
  output reg                    csum_usable,
  output reg                    csum_trusted,
  output reg                    coal_info,
  output reg                    violation
);

  reg [7:0]  flags;
  reg [7:0]  kind;
  reg [15:0] nbuf;

  always @*
  begin
    flags = hdr[7:0];
    kind  = hdr[15:8] & `NPO_KIND_MASK;
    nbuf  = hdr[95:80];
    coal_info    = (flags & `NPO_FLAG_COAL_INFO) != 8'h00;
    // begin/position only meaningful without coalesce info
    csum_usable  = ((flags & `NPO_FLAG_NEEDS_CSUM) != 8'h00) && !coal_info;
    csum_trusted = (flags & (`NPO_FLAG_NEEDS_CSUM | `NPO_FLAG_DATA_VALID)) != 8'h00;
    violation = 1'b0;
    if (!feat[`NPO_F_MERGE] && nbuf != 16'h0001)
      violation = 1'b1;
    if (feat[`NPO_F_MERGE] && nbuf == 16'h0000)
      violation = 1'b1;
    if (!feat[`NPO_F_GUEST_CSUM] && flags != 8'h00)
      violation = 1'b1;
    if (coal_info && !feat[`NPO_F_RX_COAL])
      violation = 1'b1;
    case (kind)
      `NPO_KIND_NONE: violation = violation;
      `NPO_KIND_TCP4: violation = violation | !feat[`NPO_F_RX_TCP4];
      `NPO_KIND_TCP6: violation = violation | !feat[`NPO_F_RX_TCP6];
      `NPO_KIND_UDP:  violation = violation | !feat[`NPO_F_RX_UDP];
      default:        violation = 1'b1;
    endcase
  end

endmodule // npo_rx_hdr_check
`default_nettype wire

/* npo_ctrl.v */
// npo_ctrl.v: driver-side offload header controller (apb slave for software,
// byte streams toward the device's transmit and receive queues)
// assumes: one 20 MHz clock, device streams on the same clock, header first
// Operation
// - transmit header buffer count written as zero
// - without checksum offload all flags cleared; checksum requests refused
// - segmentation kind used only when its host feature exists
// - ecn segmented tcp only with congestion feature, then ecn bit set
// - begin and position passed through only with needs-checksum
// - no host segmentation features means kind none always
// - segmenting sets needs-checksum and fills segment payload size
// - header-length hint filled when any host segmentation feature exists
// - data-valid and coalesce-info flags never set on transmit
// - posted buffers at least 65562 or 1526 bytes without merging
// - with merging every buffer at least header sized
// - multi-queue: post buffers on every used receive queue (one queue's buffer size checked here; mq bit not acted on)
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "npo_consts.vh"

module npo_ctrl (
  // clock, reset, enable
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        clk_en,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // transmit byte stream to device
  output reg  [7:0]  tx_data,
  output reg         tx_valid,
  output reg         tx_last,
  input  wire        tx_ready,
  // receive byte stream from device
  input  wire [7:0]  rx_data,
  input  wire        rx_valid,
  input  wire        rx_last,
  output wire        rx_ready,
  // receive buffer posting check
  output reg         rxbuf_ok
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_HDR  = 4'b0010;
  localparam [3:0] ST_PAY  = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;

  reg  [`NPO_FEAT_W-1:0] feat;
  reg  [7:0]             req_kind;
  reg                    req_ecn;
  reg                    req_csum;
  reg  [15:0]            req_hlen;
  reg  [15:0]            req_segsz;
  reg  [15:0]            req_cstart;
  reg  [15:0]            req_cpos;
  reg  [15:0]            pay_len;
  reg  [16:0]            bufsz;
  reg  [3:0]             tx_state;
  reg  [15:0]            tx_cnt;
  reg  [95:0]            tx_hdr;
  reg                    tx_bad;
  reg                    tx_done;
  reg  [95:0]            rx_hdr;
  reg  [3:0]             rx_idx;
  reg                    rx_in_hdr;
  reg                    rx_hdr_done;
  reg  [16:0]            rx_len;
  reg                    rx_over;
  reg                    rx_viol;
  wire [95:0]            built_hdr;
  wire                   built_bad;
  wire                   csum_usable;
  wire                   csum_trusted;
  wire                   coal_info;
  wire                   hdr_viol;
  wire                   wr_en;
  wire                   seg_rx;

  // apb: zero-wait, every access completes in its access phase
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = clk_en && psel && penable && pwrite;
  assign rx_ready = clk_en;
  assign seg_rx = feat[`NPO_F_RX_TCP4] | feat[`NPO_F_RX_TCP6] | feat[`NPO_F_RX_UDP];

  function [7:0] hdr_byte;
    input [95:0] h;
    input [3:0]  i;
    begin
      hdr_byte = h[{i, 3'b000} +: 8];
    end
  endfunction

  npo_tx_hdr_build u_build (
    .feat       (feat),
    .req_kind   (req_kind),
    .req_ecn    (req_ecn),
    .req_csum   (req_csum),
    .req_hlen   (req_hlen),
    .req_segsz  (req_segsz),
    .req_cstart (req_cstart),
    .req_cpos   (req_cpos),
    .hdr        (built_hdr),
    .bad        (built_bad)
  );

  npo_rx_hdr_check u_check (
    .feat         (feat),
    .hdr          (rx_hdr),
    .csum_usable  (csum_usable),
    .csum_trusted (csum_trusted),
    .coal_info    (coal_info),
    .violation    (hdr_viol)
  );

  // register writes
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      feat       <= {`NPO_FEAT_W{1'b0}};
      req_kind   <= `NPO_KIND_NONE;
      req_ecn    <= 1'b0;
      req_csum   <= 1'b0;
      req_hlen   <= 16'h0000;
      req_segsz  <= 16'h0000;
      req_cstart <= 16'h0000;
      req_cpos   <= 16'h0000;
      pay_len    <= 16'h0000;
      bufsz      <= 17'h00000;
    end
    else if (wr_en)
    begin
      case (paddr)
        `NPO_REG_CTRL:
        begin
          req_ecn  <= pwdata[`NPO_C_ECN];
          req_csum <= pwdata[`NPO_C_CSUM];
          req_kind <= pwdata[15:8];
          pay_len  <= pwdata[31:16];
        end
        `NPO_REG_FEAT:  feat <= pwdata[`NPO_FEAT_W-1:0];
        `NPO_REG_TXA:
        begin
          req_hlen  <= pwdata[15:0];
          req_segsz <= pwdata[31:16];
        end
        `NPO_REG_TXB:
        begin
          req_cstart <= pwdata[15:0];
          req_cpos   <= pwdata[31:16];
        end
        `NPO_REG_BUFSZ: bufsz <= pwdata[16:0];
        default: bufsz <= bufsz;
      endcase
    end
  end

  // posted buffer size
  // one receive queue served here; with mq each used queue gets this same
  always @(posedge ref_clk)
  begin
    if (sys_rst)
      rxbuf_ok <= 1'b0;
    else if (clk_en)
    begin
      if (feat[`NPO_F_MERGE])
        rxbuf_ok <= bufsz >= `NPO_RXBUF_MIN_MERGE;
      else if (seg_rx)
        rxbuf_ok <= bufsz >= `NPO_RXBUF_MIN_LARGE;
      else
        rxbuf_ok <= bufsz >= `NPO_RXBUF_MIN_SMALL;
    end
  end

  // transmit: header bytes first, little-endian, then payload count
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      tx_state <= ST_IDLE;
      tx_cnt   <= 16'h0000;
      tx_hdr   <= 96'h0;
      tx_bad   <= 1'b0;
      tx_done  <= 1'b0;
      tx_data  <= 8'h00;
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
    end
    else if (clk_en)
    begin
      case (tx_state)
        ST_IDLE:
        begin
          if (wr_en && paddr == `NPO_REG_CTRL && pwdata[`NPO_C_GO])
          begin
            tx_done  <= 1'b0;
            tx_state <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          // one cycle after go so built header sees the new request
          tx_hdr <= built_hdr;
          tx_bad <= built_bad;
          if (built_bad)
          begin
            tx_done  <= 1'b1;  // refused, nothing sent
            tx_state <= ST_IDLE;
          end
          else
          begin
            tx_data  <= hdr_byte(built_hdr, 4'd0);
            tx_valid <= 1'b1;
            tx_last  <= 1'b0;
            tx_cnt   <= 16'h0000;
            tx_state <= ST_HDR;
          end
        end
        ST_HDR:
        begin
          if (tx_ready)
          begin
            if (tx_cnt[3:0] == `NPO_HDR_LAST)
            begin
              tx_cnt   <= 16'h0000;
              tx_data  <= 8'h00;
              tx_last  <= (pay_len == 16'h0001);
              tx_valid <= (pay_len != 16'h0000);
              tx_state <= (pay_len != 16'h0000) ? ST_PAY : ST_IDLE;
              tx_done  <= (pay_len == 16'h0000);
            end
            else
            begin
              tx_cnt  <= tx_cnt + 16'h0001;
              tx_data <= hdr_byte(tx_hdr, tx_cnt[3:0] + 4'd1);
            end
          end
        end
        ST_PAY:
        begin
          // payload is a counting pattern; real data path lies beyond this block
          if (tx_ready)
          begin
            if (tx_last)
            begin
              tx_valid <= 1'b0;
              tx_last  <= 1'b0;
              tx_done  <= 1'b1;
              tx_state <= ST_IDLE;
            end
            else
            begin
              tx_cnt  <= tx_cnt + 16'h0001;
              tx_data <= tx_cnt[7:0] + 8'h01;
              tx_last <= (tx_cnt + 16'h0002 == pay_len);
            end
          end
        end
        default: tx_state <= ST_IDLE;
      endcase
    end
  end

  // receive: capture header from first buffer only, then count frame
  always @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rx_hdr      <= 96'h0;
      rx_idx      <= 4'h0;
      rx_in_hdr   <= 1'b1;
      rx_hdr_done <= 1'b0;
      rx_len      <= 17'h00000;
      rx_over     <= 1'b0;
      rx_viol     <= 1'b0;
    end
    else if (clk_en && rx_valid)
    begin
      if (rx_in_hdr)
      begin
        rx_hdr[{rx_idx, 3'b000} +: 8] <= rx_data;
        rx_idx <= rx_idx + 4'h1;
        if (rx_idx == `NPO_HDR_LAST)
        begin
          rx_in_hdr   <= 1'b0;
          rx_hdr_done <= 1'b1;
          rx_len      <= 17'h00000;
        end
      end
      else
      begin
        rx_len <= rx_len + 17'h00001;
        // frame bound
        if (rx_len + 17'h00001 + {13'h0, `NPO_HDR_BYTES} >
            (seg_rx ? `NPO_RXBUF_MIN_LARGE : `NPO_RXBUF_MIN_SMALL))
          rx_over <= 1'b1;
      end
      if (rx_last)
      begin
        rx_in_hdr <= 1'b1;
        rx_idx    <= 4'h0;
      end
    end
    else if (clk_en && rx_hdr_done)
    begin
      // feature-consistency check on received header
      rx_viol <= hdr_viol;
    end
  end

  // register reads
  always @*
  begin
    case (paddr)
      `NPO_REG_CTRL:  prdata = {pay_len, req_kind, 5'h00, req_csum, req_ecn, 1'b0};
      `NPO_REG_FEAT:  prdata = {20'h0, feat};
      `NPO_REG_TXA:   prdata = {req_segsz, req_hlen};
      `NPO_REG_TXB:   prdata = {req_cpos, req_cstart};
      `NPO_REG_STAT:  prdata = {22'h0, rxbuf_ok, rx_over, rx_viol, coal_info,
                                csum_trusted, csum_usable, rx_hdr_done, tx_bad,
                                tx_done, (tx_state != ST_IDLE)};
      `NPO_REG_RXA:   prdata = rx_hdr[31:0];
      `NPO_REG_RXB:   prdata = rx_hdr[63:32];
      `NPO_REG_RXC:   prdata = rx_hdr[95:64];
      `NPO_REG_BUFSZ: prdata = {15'h0, bufsz};
      default:        prdata = 32'h0;
    endcase
  end

endmodule // npo_ctrl
`default_nettype wire

/* npo_ctrl_checker.sv */
// npo_ctrl_checker.sv: port assertions for the offload header controller
// assumes: bound into npo_ctrl, one clock, synchronous reset
`timescale 1ns/1ps
`default_nettype none
module npo_ctrl_checker (
  // clock and control
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        clk_en,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // streams
  input wire logic [7:0]  tx_data,
  input wire logic        tx_valid,
  input wire logic        tx_last,
  input wire logic        tx_ready,
  input wire logic        rxbuf_ok
);
  logic [3:0] cnt;
  logic [7:0] flg;
  wire        take = tx_valid && tx_ready && clk_en;
  // header byte index, 12 stands for payload
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || !tx_valid)
      cnt <= 4'h0;
    else if (take && cnt != 4'hc)
      cnt <= cnt + 4'h1;
    if (take && cnt == 4'h0)
      flg <= tx_data;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  AST_APB_NO_WAIT: assert property (psel && penable |-> pready && !pslverr)
    else $error("apb access not answered at once");
  AST_UNMAPPED_ZERO: assert property (psel && penable && !pwrite && paddr > 8'h20 |-> prdata == 0)
    else $error("unmapped read not zero");
  AST_RESET_IDLE: assert property (disable iff (1'b0) sys_rst |=> !tx_valid && !tx_last && !rxbuf_ok)
    else $error("outputs active after reset");
  AST_TX_HOLD: assert property (tx_valid && !take |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("tx byte changed before acceptance");
  AST_HDR_UNBROKEN: assert property (take && cnt < 4'hb |=> tx_valid)
    else $error("header stream broken");
  AST_NBUF_ZERO: assert property (tx_valid && (cnt == 4'ha || cnt == 4'hb) |-> tx_data == 8'h00)
    else $error("tx buffer count not zero");
  AST_TX_FLAGS: assert property (tx_valid && cnt == 4'h0 |-> (tx_data & 8'h06) == 8'h00)
    else $error("receive-only flag on transmit");
  AST_KIND_CODE: assert property (tx_valid && cnt == 4'h1 |-> (tx_data & 8'h7f) inside {0, 1, 3, 4})
    else $error("unknown segmentation kind");
  AST_SEG_CSUM: assert property (tx_valid && cnt == 4'h1 && tx_data[6:0] != 0 |-> flg[0])
    else $error("segmentation without needs-checksum");
  AST_NO_HDR_LAST: assert property (tx_valid && cnt < 4'hc |-> !tx_last)
    else $error("last marker inside header");
  cover property (take && tx_last);
  cover property (tx_valid && !tx_ready);
  cover property (psel && penable && pwrite && paddr == 8'h00);
endmodule // npo_ctrl_checker
bind npo_ctrl npo_ctrl_checker u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .tx_data(tx_data), .tx_valid(tx_valid),
  .tx_last(tx_last), .tx_ready(tx_ready), .rxbuf_ok(rxbuf_ok));
`default_nettype wire

/* npo_dev_model.sv */
// npo_dev_model.sv: behavioural network device facing the controller streams
// assumes: same clock as the controller; bench calls send and sets stall
`timescale 1ns/1ps
`default_nettype none
module npo_dev_model (
  // clock, reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // transmit stream from controller
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  output logic            tx_ready,
  // receive stream to controller
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            rx_last,
  input  wire logic       rx_ready
);
  logic [7:0] txq[$];
  int         n_last, n_hang;
  logic       stall;
  initial
  begin
    {tx_ready, rx_valid, rx_last, stall} = '0;
    rx_data = 8'h5a;
    n_last = 0;
    n_hang = 0;
  end
  // slow mode backs off a third of the time
  always @(posedge ref_clk)
  begin
    tx_ready <= !sys_rst && (!stall || $urandom % 3 != 0);
    if (tx_valid && tx_ready && !sys_rst)
    begin
      txq.push_back(tx_data); // header only logged, never trusted
      // frame logged whole at any length; summing and cutting left to the device
      if (tx_last)
        n_last++;
    end
  end
  task automatic send(input logic [95:0] h, input int n);
    int w;
    if (n > 1514)
      n = 1514;
    for (int i = 0; i < 12 + n; i++)
    begin
      rx_valid <= 1'b1;
      rx_data  <= i < 12 ? h[8*i +: 8] : 8'(i);
      rx_last  <= i == 11 + n;
      w = 0;
      do begin @(posedge ref_clk); w++; end while (rx_ready !== 1'b1 && w < 20);
      if (rx_ready !== 1'b1)
        n_hang++;
    end
    // released line shows the inverse, not a stale byte
    rx_valid <= 1'b0;
    rx_last  <= 1'b0;
    rx_data  <= ~rx_data;
  endtask
endmodule // npo_dev_model
`default_nettype wire

/* test_net_packet_offload_header.sv */
// test_net_packet_offload_header.sv: self-checking bench for npo_ctrl
// assumes: npo_dev_model on the streams, checker bound to the controller
`timescale 1ns/1ps
`default_nettype none
module test_net_packet_offload_header;
  logic        ref_clk, sys_rst, clk_en, psel, penable, pwrite;
  logic [7:0]  paddr, k;
  logic [31:0] pwdata, q;
  wire  [31:0] prdata;
  wire  [7:0]  tx_data, rx_data;
  wire         pready, pslverr, tx_valid, tx_last, tx_ready;
  wire         rx_valid, rx_last, rx_ready, rxbuf_ok;
  int          n_fail, num_checks;
  localparam logic [7:0]   KT [4] = '{8'h00, 8'h01, 8'h03, 8'h04};
  localparam logic [21:0]  CT [7] = '{{12'h000, 8'h00, 2'b00}, {12'h000, 8'h01, 2'b00},
    {12'h001, 8'h00, 2'b01}, {12'h000, 8'h00, 2'b01}, {12'h013, 8'h01, 2'b10},
    {12'h003, 8'h01, 2'b10}, {12'h00f, 8'h03, 2'b00}};
  localparam logic [29:0]  BT [6] = '{{12'h200, 17'd12, 1'b1}, {12'h200, 17'd11, 1'b0},
    {12'h020, 17'd65562, 1'b1}, {12'h020, 17'd65561, 1'b0}, {12'h000, 17'd1526, 1'b1},
    {12'h000, 17'd1525, 1'b0}};
  localparam logic [107:0] RT [7] = '{{12'h820, 96'h0001_0010_0022_05b4_0036_0101},
    {12'h000, 96'h0002_0000_0000_0000_0000_0000}, {12'h200, 96'h0002_0000_0000_0000_0000_0000},
    {12'h000, 96'h0001_0000_0000_0000_0000_0002}, {12'h000, 96'h0001_0000_0000_05b4_0000_0400},
    {12'h920, 96'h0001_0001_0003_05b4_0036_0105}, {12'h820, 96'h0001_0001_0003_05b4_0036_0105}};
  npo_ctrl uut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_last(rx_last), .rx_ready(rx_ready), .rxbuf_ok(rxbuf_ok));
  npo_dev_model dev (.ref_clk(ref_clk), .sys_rst(sys_rst), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_last(rx_last), .rx_ready(rx_ready));
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  task results;
    $display("mismatches %0d of %0d checks", n_fail, num_checks);
    if (n_fail == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, msk, input string m);
    num_checks++;
    if ((got & msk) !== (exp & msk))
    begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one transfer; request held until pready is seen, then an idle cycle
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge ref_clk); n++; end while (pready !== 1'b1 && n < 20);
    q = prdata;
    if (pready !== 1'b1)
    begin
      n_fail++;
      results;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  // {refused, header}; refused when a needed feature is absent
  function automatic logic [96:0] exp_tx(input logic [11:0] f, input logic [7:0] k,
                                         input logic e, c, input logic [63:0] fl);
    logic b, n;
    n = c || k != 8'h00;
    b = (k == 8'h01 && !f[1]) || (k == 8'h04 && !f[2]) || (k == 8'h03 && !f[3])
      || (e && !f[4]) || (n && !f[0]);
    return {b, 16'h0000, n ? fl[63:32] : 32'h0, fl[31:0], k | {e, 7'h0}, 7'h0, n};
  endfunction
  // {violation, coalesce info, checksum usable}
  function automatic logic [2:0] exp_rx(input logic [11:0] f, input logic [95:0] h);
    logic v;
    v = (h[95:80] != 16'h0001 && !f[9]) || (h[95:80] == 16'h0000 && f[9])
      || (h[7:0] != 8'h00 && !f[11]) || (h[2] && !f[8])
      || (h[14:8] == 7'h01 && !f[5]) || (h[14:8] == 7'h04 && !f[6])
      || (h[14:8] == 7'h03 && !f[7]);
    return {v, h[2], h[0] && !h[2]};
  endfunction
  task automatic tx(input logic [11:0] f, input logic [7:0] k, input logic e, c,
                    input logic [15:0] pl);
    logic [63:0] fl;
    logic [96:0] x;
    logic [95:0] m;
    int          n, l0;
    fl = {$urandom, $urandom};
    x  = exp_tx(f, k, e, c, fl);
    // hint and payload size are free when not in use
    m  = {48'hffff_ffff_ffff, {16{k != 8'h00}}, {16{f[3:1] != 3'h0}}, 16'hffff};
    l0 = dev.n_last;
    dev.txq.delete();
    apb(8'h04, 1'b1, {20'h0, f});
    apb(8'h08, 1'b1, fl[31:0]);
    apb(8'h0c, 1'b1, fl[63:32]);
    apb(8'h00, 1'b1, {pl, k, 5'h0, c, e, 1'b1});
    n = 0;
    do begin apb(8'h10, 1'b0, 0); n++; end while (q[2:1] === 2'b00 && n < 80);
    if (q[2:1] === 2'b00)
    begin
      n_fail++;
      results;
    end
    chk(q[2:0], {x[96], 2'b10}, 7, "refusal");
    chk(dev.txq.size(), x[96] ? 0 : 12 + pl, '1, "byte count");
    chk(dev.n_last - l0, !x[96] && pl != 0, '1, "last marker");
    for (int i = 0; i < dev.txq.size(); i++)
      chk(dev.txq[i], i < 12 ? x[8*i +: 8] : i - 12, i < 12 ? m[8*i +: 8] : 8'hff, "tx byte");
  endtask
  task automatic rx(input logic [11:0] f, input logic [95:0] h, input int n);
    logic [2:0] v;
    v = exp_rx(f, h);
    apb(8'h04, 1'b1, {20'h0, f});
    dev.send(h, n);
    apb(8'h10, 1'b0, 0);
    chk(q[7], v[2], 1, "rx violation");
    chk(q[6:3], {v[1], h[0] | h[1], v[0], 1'b1}, 15, "rx checksum use");
    chk(q[8], 0, 1, "frame bound");
    chk(dev.n_hang, 0, '1, "rx stream stalled");
    for (int i = 0; i < 3; i++)
    begin
      apb(8'h14 + 8'(4 * i), 1'b0, 0);
      chk(q, h[32*i +: 32], '1, "rx header word");
    end
  endtask
  initial
  begin
    {clk_en, psel, penable, pwrite, paddr, pwdata, n_fail, num_checks} = '0;
    sys_rst = 1'b1;
    clk_en  = 1'b1;
    void'($urandom(32'hec9e74bc));
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    for (int a = 0; a <= 32; a += 4)
    begin
      apb(8'(a), 1'b0, 0);
      chk(q, 0, '1, "reset value");
    end
    apb(8'h04, 1'b1, '1);
    clk_en <= 1'b0;
    apb(8'h04, 1'b1, 0);
    clk_en <= 1'b1;
    apb(8'h04, 1'b0, 0);
    chk(q, 32'hfff, 32'hfff, "frozen write kept out");
    apb(8'h40, 1'b1, '1);
    apb(8'h40, 1'b0, 0);
    chk(q, 0, '1, "unmapped read");
    foreach (BT[i])
    begin
      apb(8'h04, 1'b1, {20'h0, BT[i][29:18]});
      apb(8'h20, 1'b1, {15'h0, BT[i][17:1]});
      apb(8'h10, 1'b0, 0);
      chk(q[9], BT[i][0], 1, "buffer size status");
      chk(rxbuf_ok, BT[i][0], 1, "buffer size port");
    end
    foreach (CT[i])
      tx(CT[i][21:10], CT[i][9:2], CT[i][1], CT[i][0], 16'd3);
    dev.stall <= 1'b1;
    repeat (40)
    begin
      k = KT[$urandom % 4];
      tx(12'($urandom), k, (k == 8'h01 || k == 8'h04) && $urandom % 2, 1'($urandom), 16'($urandom % 6));
    end
    foreach (RT[i])
      rx(RT[i][107:96], RT[i][95:0], 4);
    rx(12'h200, 96'h0, 4);
    rx(12'h000, 96'h0001_0000_0000_0000_0000_0000, 1514);
    results;
  end
endmodule // test_net_packet_offload_header
`default_nettype wire
